// [verilog/pid_loop_consts.svh]
// Purpose: constants for the analog process-loop block
// Assumes: 40 MHz clock, 16-bit signed sample words
// Notes: included by the design files
`ifndef PID_LOOP_CONSTS_SVH
`define PID_LOOP_CONSTS_SVH
`define CLK_FREQ_HZ 40000000
`define MS_CYCLES (`CLK_FREQ_HZ / 1000)
`define N_CHAN 8
`define N_LOOP_MAX 6
`define N_LOOP_BASE 2
`define ADC12_SHIFT 4
`define MID_UNI 16'h0800
`define MID_BI 16'h0000
`define PERIOD_RST 16'h0019
`define SETPOINT_RST 16'h0000
`define DEADBAND_RST 16'h0000
`define RANGE_RST 3'h3
`endif

// [verilog/pid_loop_pkg.sv]
// Purpose: types for the analog process-loop block
// Assumes: nothing
// Notes: constants live in the header
package pid_loop_pkg;
   typedef enum logic [1:0] {
      VAR_FIXED = 2'b00,
      VAR_CONFIG = 2'b01,
      VAR_NO_OUT = 2'b10
   } variant_e;
   typedef enum logic [2:0] {
      RNG_PM5 = 3'b001,
      RNG_PM10 = 3'b010,
      RNG_0_5 = 3'b011,
      RNG_0_10 = 3'b100
   } range_e;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_ERR = 2'b01,
      ST_FILT = 2'b10,
      ST_OUT = 2'b11
   } loop_state_e;
endpackage

// [verilog/input_conditioner.sv]
// Purpose: input pairing and resolution for the analog channels
// Assumes: raw codes left-justified, 16 bits signed
// Notes: one instance per channel pair
`timescale 1ns/1ps
`include "pid_loop_consts.svh"
module input_conditioner (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // configuration
   input wire logic diff_i,
   input wire logic res16_i,
   // raw samples
   input wire logic signed [15:0] raw_a_i,
   input wire logic signed [15:0] raw_b_i,
   // conditioned values
   output logic signed [15:0] val_a_o,
   output logic signed [15:0] val_b_o
);
   logic signed [15:0] a_t;
   logic signed [15:0] b_t;
   logic signed [15:0] dif_t;
   always_comb begin
      // 12-bit parts drop the low nibble
      a_t = res16_i ? raw_a_i : ((raw_a_i >>> `ADC12_SHIFT) <<< `ADC12_SHIFT);
      b_t = res16_i ? raw_b_i : ((raw_b_i >>> `ADC12_SHIFT) <<< `ADC12_SHIFT);
      dif_t = 16'(a_t - b_t);
   end
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         val_a_o <= 16'h0000;
         val_b_o <= 16'h0000;
      end else if (diff_i) begin
         val_a_o <= dif_t;
         val_b_o <= dif_t;
      end else begin
         val_a_o <= a_t;
         val_b_o <= b_t;
      end
   end
endmodule // input_conditioner

// [verilog/pid_core.sv]
// Purpose: one PID loop instance with deadband, clamp and update timer
// Assumes: gains in Q8.8, values signed 16-bit
// Notes: instantiated once per loop
`timescale 1ns/1ps
`include "pid_loop_consts.svh"
module pid_core (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // control
   input wire logic enable_i,
   input wire logic bipolar_i,
   input wire logic [15:0] loop_update_period_i,
   input wire logic signed [15:0] proportional_gain_i,
   input wire logic signed [15:0] integral_gain_i,
   input wire logic signed [15:0] derivative_gain_i,
   input wire logic signed [15:0] integrator_clamp_i,
   input wire logic signed [15:0] dead_zone_width_i,
   input wire logic signed [15:0] commanded_setpoint_i,
   input wire logic signed [15:0] feedback_i,
   // results
   output logic signed [15:0] drive_o,
   output logic signed [15:0] error_readback_o,
   output logic update_o
);
   logic [15:0] ms_q;
   logic [15:0] per_q;
   logic tick_q;
   logic signed [31:0] integ_q;
   logic signed [16:0] prev_q;
   logic signed [16:0] err_t;
   logic [16:0] mag_t;
   logic [16:0] band_t;
   logic inside_t;
   logic signed [31:0] integ_d;
   logic signed [31:0] lim_t;
   logic signed [47:0] sum_t;
   logic signed [31:0] mid_t;
   logic signed [31:0] out_t;
   // update period timer
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ms_q <= 16'h0000;
         per_q <= 16'h0000;
         tick_q <= 1'b0;
      end else begin
         tick_q <= 1'b0;
         if (ms_q == 16'(`MS_CYCLES - 1)) begin
            ms_q <= 16'h0000;
            if (per_q + 16'h0001 >= loop_update_period_i) begin
               per_q <= 16'h0000;
               tick_q <= 1'b1;
            end else begin
               per_q <= per_q + 16'h0001;
            end
         end else begin
            ms_q <= ms_q + 16'h0001;
         end
      end
   end
   always_comb begin
      err_t = 17'(commanded_setpoint_i) - 17'(feedback_i);
      mag_t = err_t[16] ? 17'(-err_t) : 17'(err_t);
      band_t = dead_zone_width_i[15] ? 17'(-17'(dead_zone_width_i)) : 17'(dead_zone_width_i);
      inside_t = (mag_t < band_t);
      lim_t = integrator_clamp_i[15] ? -32'(integrator_clamp_i) : 32'(integrator_clamp_i);
      integ_d = integ_q + 32'(err_t) * 32'(integral_gain_i);
      if (integ_d > (lim_t <<< 8)) begin
         integ_d = lim_t <<< 8;
      end else if (integ_d < -(lim_t <<< 8)) begin
         integ_d = -(lim_t <<< 8);
      end
      sum_t = 48'(err_t) * 48'(proportional_gain_i) + 48'(integ_d)
         + 48'(err_t - prev_q) * 48'(derivative_gain_i);
      mid_t = bipolar_i ? 32'(`MID_BI) : 32'(`MID_UNI);
      out_t = mid_t + 32'(sum_t >>> 8);
      if (out_t > 32'sh7FFF) begin
         out_t = 32'sh7FFF;
      end else if (out_t < -32'sh8000) begin
         out_t = -32'sh8000;
      end
   end
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         integ_q <= 32'h0000_0000;
         prev_q <= 17'h00000;
         drive_o <= 16'h0000;
         update_o <= 1'b0;
      end else begin
         update_o <= 1'b0;
         if (!enable_i) begin
            integ_q <= 32'h0000_0000;
            prev_q <= 17'h00000;
            drive_o <= 16'h0000;
         end else if (tick_q) begin
            update_o <= 1'b1;
            if (inside_t && dead_zone_width_i[15]) begin
               // flow mode: hold output and terms
               drive_o <= drive_o;
            end else if (inside_t) begin
               // small deviation: drive set to midpoint plus held integral term, terms held
               drive_o <= 16'(mid_t + 32'(integ_q >>> 8));
            end else begin
               integ_q <= integ_d;
               prev_q <= err_t;
               drive_o <= 16'(out_t);
            end
         end
      end
   end
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         error_readback_o <= 16'h0000;
      end else begin
         error_readback_o <= 16'(err_t);
      end
   end
endmodule // pid_core

// [verilog/analog_pid_process_loop.sv]
// Purpose: analog input conditioning and PID process loops
// Assumes: all parameters loaded over plain ports by a command decoder
// Notes: host sets ranges before enabling loops
`timescale 1ns/1ps
`include "pid_loop_consts.svh"
module analog_pid_process_loop (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // hardware style
   input wire logic [1:0] hardware_style_query_i,
   input wire logic extended_i,
   input wire logic res16_option_i,
   // input range configuration command
   input wire logic input_range_config_wr_i,
   input wire logic [2:0] input_range_chan_i,
   input wire logic signed [3:0] input_range_code_i,
   // loop parameter write
   input wire logic param_wr_i,
   input wire logic [2:0] param_loop_i,
   input wire logic [3:0] param_sel_i,
   input wire logic signed [15:0] param_data_i,
   input wire logic save_parameters_nonvolatile_i,
   input wire logic [5:0] loop_enable_i,
   // samples
   input wire logic [127:0] raw_samples_i,
   // results
   output logic [127:0] analog_values_o,
   output logic [23:0] input_range_o,
   output logic [3:0] diff_pairs_o,
   output logic [127:0] drive_values_o,
   output logic [95:0] error_readback_o,
   output logic [5:0] loop_updated_o,
   output logic [5:0] loop_present_o,
   output logic save_done_o
);
   // parameter selectors
   localparam logic [3:0] P_FEEDBACK = 4'h0;
   localparam logic [3:0] P_DRIVE = 4'h1;
   localparam logic [3:0] P_KP = 4'h2;
   localparam logic [3:0] P_KD = 4'h3;
   localparam logic [3:0] P_KI = 4'h4;
   localparam logic [3:0] P_IL = 4'h5;
   localparam logic [3:0] P_DB = 4'h6;
   localparam logic [3:0] P_CL = 4'h7;
   localparam logic [3:0] P_SP = 4'h8;

   // ----------------------------------------
   // input range configuration
   // ----------------------------------------
   pid_loop_pkg::variant_e var_t;
   logic [3:0] diff_q;
   logic [2:0] range_q [`N_CHAN];
   logic [2:0] code_mag_t;
   assign var_t = pid_loop_pkg::variant_e'(hardware_style_query_i);
   assign code_mag_t = input_range_code_i[3] ? 3'(-input_range_code_i) : 3'(input_range_code_i);
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         diff_q <= 4'h0;
         for (int i = 0; i < `N_CHAN; i++) begin
            range_q[i] <= `RANGE_RST;
         end
      end else if (input_range_config_wr_i) begin
         if (var_t == pid_loop_pkg::VAR_FIXED) begin
            // even channel with operand 1 pairs with next odd
            if (!input_range_chan_i[0]) begin
               diff_q[input_range_chan_i[2:1]] <= (input_range_code_i == 4'sh1);
            end
         end else if (input_range_code_i[3]) begin
            if (!input_range_chan_i[0] && code_mag_t >= 3'h1 && code_mag_t <= 3'h4) begin
               diff_q[input_range_chan_i[2:1]] <= 1'b1;
               range_q[input_range_chan_i] <= code_mag_t;
               range_q[input_range_chan_i + 3'h1] <= code_mag_t;
            end
         end else if (code_mag_t >= 3'h1 && code_mag_t <= 3'h4) begin
            range_q[input_range_chan_i] <= code_mag_t;
            diff_q[input_range_chan_i[2:1]] <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // input conditioning
   // ----------------------------------------
   logic [127:0] cond_t;
   logic res16_t;
   // fixed variant always 12 bits
   assign res16_t = res16_option_i && (var_t != pid_loop_pkg::VAR_FIXED);
   for (genvar p = 0; p < 4; p++) begin : g_pair
      input_conditioner u_cond (
         .clk_i(clk_i),
         .rst_n_i(rst_n_i),
         .diff_i(diff_q[p]),
         .res16_i(res16_t),
         .raw_a_i(raw_samples_i[32*p +: 16]),
         .raw_b_i(raw_samples_i[32*p+16 +: 16]),
         .val_a_o(cond_t[32*p +: 16]),
         .val_b_o(cond_t[32*p+16 +: 16])
      );
   end
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         analog_values_o <= '0;
         diff_pairs_o <= 4'h0;
         input_range_o <= '0;
      end else begin
         analog_values_o <= cond_t;
         diff_pairs_o <= diff_q;
         for (int i = 0; i < `N_CHAN; i++) begin
            input_range_o[3*i +: 3] <= range_q[i];
         end
      end
   end

   // ----------------------------------------
   // loop parameters
   // ----------------------------------------
   logic [2:0] fb_q [`N_LOOP_MAX];
   logic [2:0] dr_q [`N_LOOP_MAX];
   logic signed [15:0] kp_q [`N_LOOP_MAX];
   logic signed [15:0] kd_q [`N_LOOP_MAX];
   logic signed [15:0] ki_q [`N_LOOP_MAX];
   logic signed [15:0] il_q [`N_LOOP_MAX];
   logic signed [15:0] db_q [`N_LOOP_MAX];
   logic [15:0] cl_q [`N_LOOP_MAX];
   logic signed [15:0] sp_q [`N_LOOP_MAX];
   // saved copy of burnable parameters
   logic [2:0] fb_s [`N_LOOP_MAX];
   logic [2:0] dr_s [`N_LOOP_MAX];
   logic signed [15:0] kp_s [`N_LOOP_MAX];
   logic signed [15:0] kd_s [`N_LOOP_MAX];
   logic signed [15:0] ki_s [`N_LOOP_MAX];
   logic signed [15:0] il_s [`N_LOOP_MAX];
   logic [15:0] cl_s [`N_LOOP_MAX];
   logic [5:0] present_t;
   always_comb begin
      if (var_t == pid_loop_pkg::VAR_NO_OUT) begin
         present_t = 6'h00;
      end else if (extended_i) begin
         present_t = 6'h3F;
      end else begin
         present_t = 6'h03;
      end
   end
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         for (int l = 0; l < `N_LOOP_MAX; l++) begin
            fb_q[l] <= 3'h0;
            dr_q[l] <= 3'h0;
            kp_q[l] <= 16'h0000;
            kd_q[l] <= 16'h0000;
            ki_q[l] <= 16'h0000;
            il_q[l] <= 16'h0000;
            db_q[l] <= `DEADBAND_RST;
            cl_q[l] <= `PERIOD_RST;
            sp_q[l] <= `SETPOINT_RST;
         end
      end else if (param_wr_i && param_loop_i < 3'(`N_LOOP_MAX)) begin
         case (param_sel_i)
            P_FEEDBACK: fb_q[param_loop_i] <= param_data_i[2:0];
            P_DRIVE: dr_q[param_loop_i] <= param_data_i[2:0];
            P_KP: kp_q[param_loop_i] <= param_data_i;
            P_KD: kd_q[param_loop_i] <= param_data_i;
            P_KI: ki_q[param_loop_i] <= param_data_i;
            P_IL: il_q[param_loop_i] <= param_data_i;
            P_DB: db_q[param_loop_i] <= param_data_i;
            P_CL: cl_q[param_loop_i] <= param_data_i;
            P_SP: sp_q[param_loop_i] <= param_data_i;
            default: ;
         endcase
      end
   end
   // save excludes setpoint, deadband and ranges
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         save_done_o <= 1'b0;
         for (int l = 0; l < `N_LOOP_MAX; l++) begin
            fb_s[l] <= 3'h0;
            dr_s[l] <= 3'h0;
            kp_s[l] <= 16'h0000;
            kd_s[l] <= 16'h0000;
            ki_s[l] <= 16'h0000;
            il_s[l] <= 16'h0000;
            cl_s[l] <= `PERIOD_RST;
         end
      end else begin
         save_done_o <= save_parameters_nonvolatile_i;
         if (save_parameters_nonvolatile_i) begin
            for (int l = 0; l < `N_LOOP_MAX; l++) begin
               fb_s[l] <= fb_q[l];
               dr_s[l] <= dr_q[l];
               kp_s[l] <= kp_q[l];
               kd_s[l] <= kd_q[l];
               ki_s[l] <= ki_q[l];
               il_s[l] <= il_q[l];
               cl_s[l] <= cl_q[l];
            end
         end
      end
   end

   // ----------------------------------------
   // loop instances
   // ----------------------------------------
   logic [95:0] drive_t;
   logic [95:0] err_t;
   logic [5:0] upd_t;
   for (genvar l = 0; l < `N_LOOP_MAX; l++) begin : g_loop
      logic bip_t;
      assign bip_t = (range_q[fb_q[l]] == 3'(pid_loop_pkg::RNG_PM5))
         || (range_q[fb_q[l]] == 3'(pid_loop_pkg::RNG_PM10));
      pid_core u_pid (
         .clk_i(clk_i),
         .rst_n_i(rst_n_i),
         .enable_i(loop_enable_i[l] && present_t[l]),
         .bipolar_i(bip_t),
         .loop_update_period_i(cl_q[l]),
         .proportional_gain_i(kp_q[l]),
         .integral_gain_i(ki_q[l]),
         .derivative_gain_i(kd_q[l]),
         .integrator_clamp_i(il_q[l]),
         .dead_zone_width_i(db_q[l]),
         .commanded_setpoint_i(sp_q[l]),
         .feedback_i(cond_t[16*fb_q[l] +: 16]),
         .drive_o(drive_t[16*l +: 16]),
         .error_readback_o(err_t[16*l +: 16]),
         .update_o(upd_t[l])
      );
   end
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         drive_values_o <= '0;
         error_readback_o <= '0;
         loop_updated_o <= 6'h00;
         loop_present_o <= 6'h00;
      end else begin
         error_readback_o <= err_t;
         loop_updated_o <= upd_t;
         loop_present_o <= present_t;
         for (int l = 0; l < `N_LOOP_MAX; l++) begin
            if (present_t[l] && loop_enable_i[l]) begin
               drive_values_o[16*dr_q[l] +: 16] <= drive_t[16*l +: 16];
            end
         end
      end
   end
endmodule // analog_pid_process_loop

// [verif/pid_loop_sva.sv]
// Purpose: port-level assertions for the process-loop block
// Assumes: single clock domain, async active-low reset
// Notes: bound to the top module below
`timescale 1ns/1ps
module pid_loop_sva (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // controls
   input wire logic [1:0] hardware_style_query_i,
   input wire logic extended_i,
   input wire logic input_range_config_wr_i,
   input wire logic [2:0] input_range_chan_i,
   input wire logic signed [3:0] input_range_code_i,
   input wire logic save_parameters_nonvolatile_i,
   // results
   input wire logic [127:0] analog_values_o,
   input wire logic [23:0] input_range_o,
   input wire logic [3:0] diff_pairs_o,
   input wire logic [5:0] loop_updated_o,
   input wire logic [5:0] loop_present_o,
   input wire logic save_done_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_n_i);
   // ----------------------------------------
   // config write sequence and port assertions
   // ----------------------------------------
   sequence s_cfg(chan, code);
      input_range_config_wr_i && input_range_chan_i == chan && input_range_code_i == code;
   endsequence
   a_fixed_pair_set: assert property (s_cfg(3'h2, 4'sh1) ##0 hardware_style_query_i == 2'h0
      |-> ##2 diff_pairs_o[1]) else $error("pair not formed");
   a_odd_chan_ignored: assert property (s_cfg(3'h3, 4'sh1) ##0 hardware_style_query_i == 2'h0
      |-> ##2 $stable(diff_pairs_o[1])) else $error("odd channel changed pairing");
   a_range_code_set: assert property (s_cfg(3'h1, 4'sh2) ##0 hardware_style_query_i == 2'h1
      |-> ##2 input_range_o[5:3] == 3'h2) else $error("range code not applied");
   a_neg_code_pair: assert property (s_cfg(3'h4, 4'shE) ##0 hardware_style_query_i == 2'h1
      |-> ##2 diff_pairs_o[2] && input_range_o[14:12] == 3'h2) else $error("negative code");
   a_diff_both_chan: assert property (diff_pairs_o[1] [*4]
      |-> analog_values_o[47:32] == analog_values_o[63:48]) else $error("pair values differ");
   a_present_base: assert property ((hardware_style_query_i == 2'h0 && !extended_i) [*3]
      |-> loop_present_o == 6'h03) else $error("base loop count");
   a_present_ext: assert property ((hardware_style_query_i == 2'h0 && extended_i) [*3]
      |-> loop_present_o == 6'h3F) else $error("extended loop count");
   a_present_none: assert property ((hardware_style_query_i == 2'h2) [*3]
      |-> loop_present_o == 6'h00) else $error("loops without outputs");
   a_save_done_pulse: assert property (save_parameters_nonvolatile_i |=> save_done_o)
      else $error("save not acknowledged");
   a_save_done_cause: assert property (save_done_o |-> $past(save_parameters_nonvolatile_i))
      else $error("spurious save acknowledge");
   a_update_single: assert property (loop_updated_o[0] |=> !loop_updated_o[0])
      else $error("update pulse too long");
endmodule // pid_loop_sva
bind analog_pid_process_loop pid_loop_sva u_sva (.clk_i, .rst_n_i, .hardware_style_query_i,
   .extended_i, .input_range_config_wr_i, .input_range_chan_i, .input_range_code_i,
   .save_parameters_nonvolatile_i, .analog_values_o, .input_range_o, .diff_pairs_o,
   .loop_updated_o, .loop_present_o, .save_done_o);

// [verif/sensor_bank.sv]
// Purpose: sensor side model feeding raw converter samples
// Assumes: values loaded one channel at a time
// Notes: no reset, levels persist like real sensors
`timescale 1ns/1ps
module sensor_bank (
   // clock
   input wire logic clk_i,
   // value load
   input wire logic load_i,
   input wire logic [2:0] chan_i,
   input wire logic signed [15:0] value_i,
   // samples
   output logic [127:0] raw_samples_o
);
   initial raw_samples_o = 128'h0;
   always @(posedge clk_i) begin
      if (load_i) begin
         raw_samples_o[{chan_i, 4'h0} +: 16] <= value_i;
      end
   end
endmodule // sensor_bank

// [verif/tb_top.sv]
// Purpose: self-checking bench for the process-loop block
// Assumes: inputs driven at falling edge
// Notes: expected values from a behavioural model
`timescale 1ns/1ps
module tb_top;
   logic clk_i, rst_n_i, extended_i, res16_option_i, input_range_config_wr_i, param_wr_i;
   logic save_parameters_nonvolatile_i, s_load, save_done_o;
   logic [1:0] hardware_style_query_i;
   logic [2:0] input_range_chan_i, param_loop_i, s_chan;
   logic signed [3:0] input_range_code_i;
   logic [3:0] param_sel_i, diff_pairs_o;
   logic signed [15:0] param_data_i, s_val;
   logic [5:0] loop_enable_i, loop_updated_o, loop_present_o;
   logic [127:0] raw_samples_i, analog_values_o, drive_values_o;
   logic [23:0] input_range_o;
   logic [95:0] error_readback_o;
   logic [31:0] seed = 32'h573B;
   int num_errors = 0, cmp_count = 0, smp[8], n, fb, err, lim;
   bit prs[4];
   analog_pid_process_loop uut (.clk_i, .rst_n_i, .hardware_style_query_i, .extended_i,
      .res16_option_i, .input_range_config_wr_i, .input_range_chan_i, .input_range_code_i,
      .param_wr_i, .param_loop_i, .param_sel_i, .param_data_i, .save_parameters_nonvolatile_i,
      .loop_enable_i, .raw_samples_i, .analog_values_o, .input_range_o, .diff_pairs_o,
      .drive_values_o, .error_readback_o, .loop_updated_o, .loop_present_o, .save_done_o);
   sensor_bank u_sens (.clk_i, .load_i(s_load), .chan_i(s_chan), .value_i(s_val),
      .raw_samples_o(raw_samples_i));
   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end
   // ----------------------------------------
   // model and helpers
   // ----------------------------------------
   function automatic logic [31:0] xs(logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction
   function automatic logic [15:0] model_val(int ch, bit full);
      int v;
      v = prs[ch / 2] ? smp[ch & 6] - smp[ch | 1] : smp[ch];
      if (!full) v = v & ~15;
      return v[15:0];
   endfunction
   task automatic check(logic [31:0] seen, logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic complete_run();
      $display("comparisons %0d, errors %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic do_reset(logic [1:0] sty);
      hardware_style_query_i = sty;
      rst_n_i = 1'b0;
      repeat (2) @(negedge clk_i);
      rst_n_i = 1'b1;
      prs = '{default: 1'b0};
      repeat (3) @(negedge clk_i);
   endtask
   task automatic cfg(int chan, int code);
      input_range_config_wr_i = 1'b1;
      input_range_chan_i = chan[2:0];
      input_range_code_i = code[3:0];
      @(negedge clk_i);
      input_range_config_wr_i = 1'b0;
      repeat (3) @(negedge clk_i);
   endtask
   task automatic param(int sel, int data);
      param_wr_i = 1'b1;
      param_sel_i = sel[3:0];
      param_data_i = data[15:0];
      @(negedge clk_i);
      param_wr_i = 1'b0;
      // idle cycle so back-to-back writes never re-raise the strobe at once
      @(negedge clk_i);
   endtask
   task automatic load_all();
      for (int c = 0; c < 8; c++) begin
         seed = xs(seed);
         smp[c] = $signed(seed[15:0]) >>> 2;
         if (c % 2) smp[c] = smp[c] & ~15;
         s_load = 1'b1;
         s_chan = c[2:0];
         s_val = smp[c][15:0];
         @(negedge clk_i);
      end
      s_load = 1'b0;
      repeat (4) @(negedge clk_i);
   endtask
   task automatic check_vals(bit full);
      for (int c = 0; c < 8; c++) begin
         check(analog_values_o[c * 16 +: 16], model_val(c, full));
      end
   endtask
   // bounded wait for the next loop 0 update; running out counts a mismatch
   task automatic wait_upd();
      for (n = 0; n < 45000 && loop_updated_o[0] !== 1'b1; n++) @(negedge clk_i);
      if (n == 45000) num_errors++;
   endtask
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      static logic [1:0] sty[4] = '{2'h0, 2'h0, 2'h2, 2'h1};
      static logic ext[4] = '{1'b0, 1'b1, 1'b0, 1'b0};
      static logic [5:0] lp[4] = '{6'h03, 6'h3F, 6'h00, 6'h03};
      {extended_i, res16_option_i, input_range_config_wr_i, param_wr_i, s_load} = 5'h0;
      {input_range_chan_i, input_range_code_i, param_loop_i, param_sel_i} = 14'h0;
      {param_data_i, s_val, s_chan, loop_enable_i} = 41'h0;
      save_parameters_nonvolatile_i = 1'b0;
      do_reset(2'h0);
      check(input_range_o, 24'h6DB6DB);
      check(diff_pairs_o, 4'h0);
      for (int i = 0; i < 4; i++) begin
         hardware_style_query_i = sty[i];
         extended_i = ext[i];
         repeat (4) @(negedge clk_i);
         check(loop_present_o, lp[i]);
      end
      hardware_style_query_i = 2'h0;
      extended_i = 1'b0;
      load_all();
      check_vals(1'b0);
      cfg(3, 1);
      check(diff_pairs_o, 4'h0);
      cfg(2, 1);
      prs[1] = 1'b1;
      check(diff_pairs_o, 4'h2);
      check_vals(1'b0);
      do_reset(2'h1);
      for (int k = 1; k <= 4; k++) begin
         cfg(k - 1, k);
         check(input_range_o[(k - 1) * 3 +: 3], k);
      end
      cfg(5, 0);
      cfg(3, -1);
      check(input_range_o[17:9], 9'h0DC);
      cfg(4, -2);
      prs[2] = 1'b1;
      check(diff_pairs_o, 4'h4);
      check(input_range_o[14:12], 3'h2);
      res16_option_i = 1'b1;
      load_all();
      check_vals(1'b1);
      res16_option_i = 1'b0;
      do_reset(2'h0);
      fb = $signed(model_val(0, 1'b0));
      seed = xs(seed);
      err = int'(seed[7:0]) - 128;
      param_loop_i = 3'h0;
      foreach (lp[i]) param(i, 0);
      param(2, 16'h0100);
      param(4, 16'h0100);
      param(5, 4);
      param(7, 1);
      param(8, fb + err);
      // integral term limited to +-4 output codes
      lim = (err > 4) ? 4 : ((err < -4) ? -4 : err);
      save_parameters_nonvolatile_i = 1'b1;
      @(negedge clk_i);
      save_parameters_nonvolatile_i = 1'b0;
      loop_enable_i = 6'h01;
      wait_upd();
      if (n < 45000) begin
         check(error_readback_o[15:0], err[15:0]);
         check(drive_values_o[15:0], 16'(32'h0800 + err + lim));
         param(6, 16'h7FFF);
         wait_upd();
      end
      if (n < 45000) check(drive_values_o[15:0], 16'(32'h0800 + lim));
      complete_run();
   end
endmodule // tb_top
